//--- core/srh_host.v
// host controller for self refresh, power-down and mode register access
`include "srh_defines.vh"

module srh_host #(
    parameter [7:0]  DIV        = 8'h04,
    parameter [15:0] RL_NCK     = 16'h000e,
    parameter [15:0] SAMPLE_DLY = 16'h0008,
    parameter [15:0] CKELCK_NCK = 16'h0005,
    parameter [15:0] CKCKEH_NCK = 16'h0005
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [3:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output wire [31:0] rdata,
    output wire        ck_out,
    output wire        cke,
    output wire        cs,
    output wire [5:0]  ca,
    input  wire [7:0]  dq_in
);

    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_CMD  = 3'b010;
    localparam [2:0] S_WAIT = 3'b100;
    localparam [7:0] DIV_M1 = DIV - 8'h01;

    reg [7:0]  div_cnt_q;
    reg        ck_q;
    reg        ck_run_q;
    reg [2:0]  state_q;
    reg [2:0]  op_q;
    reg [1:0]  phase_q;
    reg [15:0] arg_q;
    reg [15:0] tmr_sys_q;
    reg [15:0] tmr_ck_q;
    reg        armed_q;
    reg        cap_pend_q;
    reg [15:0] cap_ck_q;
    reg [15:0] cap_sys_q;
    reg [7:0]  mr_data_q;
    reg [7:0]  dq_s1_q;
    reg [7:0]  dq_s2_q;
    reg        cke_q;
    reg        cs_q;
    reg [5:0]  ca_q;
    reg        in_sr_q;
    reg        in_pd_q;
    reg        owed_q;
    reg [2:0]  pb_cnt_q;
    reg        abort_en_q;
    reg        err_q;
    reg [31:0] rdata_q;
    reg [15:0] ld_sys;
    reg [15:0] ld_ck;
    reg        req_ok;

    // round a time up to whole system cycles, never below one
    function [15:0] cyc;
        input [31:0] ps;
        reg   [31:0] v;
        begin
            v = (ps + `SRH_SYS_PS - 32'h00000001) / `SRH_SYS_PS;
            if (v == 32'h00000000)
                v = 32'h00000001;
            cyc = v[15:0];
        end
    endfunction

    function [15:0] max16;
        input [15:0] a;
        input [15:0] b;
        begin
            max16 = (a > b) ? a : b;
        end
    endfunction

    // command lane word for each edge of a command
    function [5:0] ca_word;
        input [2:0] op;
        input [1:0] ph;
        input [5:0] ma;
        input [7:0] dt;
        begin
            ca_word = `SRH_CA_DES;
            case (op)
            `SRH_OP_SRE:   ca_word = ph[0] ? `SRH_CA_DES : `SRH_CA_SRE;
            `SRH_OP_SRX:   ca_word = ph[0] ? `SRH_CA_DES : `SRH_CA_SRX;
            `SRH_OP_MRR:   ca_word = ph[0] ? ma : `SRH_CA_MRR; // see R15
            `SRH_OP_REFAB: ca_word = ph[0] ? `SRH_CA_DES : `SRH_CA_REFAB;
            `SRH_OP_REFPB: ca_word = ph[0] ? `SRH_CA_DES : `SRH_CA_REFPB;
            `SRH_OP_MRW: begin
                case (ph)
                2'h0:    ca_word = `SRH_CA_MRW1 | {dt[7], 5'h00};
                2'h1:    ca_word = ma;
                2'h2:    ca_word = `SRH_CA_MRW2 | {dt[6], 5'h00};
                default: ca_word = dt[5:0];
                endcase
            end
            default:       ca_word = `SRH_CA_DES;
            endcase
        end
    endfunction

    wire [2:0] req_op   = wdata[`SRH_CTRL_OP_HI:`SRH_CTRL_OP_LO];
    wire       ctrl_wr  = wr_en && (addr == `SRH_REG_CTRL);
    wire       go       = ctrl_wr && wdata[`SRH_CTRL_GO];
    wire       mask_ma  = (arg_q[5:0] == `SRH_MA_BANK_MASK) ||
                          (arg_q[5:0] == `SRH_MA_SEG_MASK) ||
                          (arg_q[5:0] == `SRH_MA_ABORT);
    wire       idle     = (state_q == S_IDLE);
    wire       accept   = go && idle && req_ok;
    wire       edge_now = (div_cnt_q == DIV_M1);
    wire       rise     = edge_now && ck_run_q && !ck_q;
    wire       fall     = edge_now && ck_q;
    wire [1:0] last_ph  = (op_q == `SRH_OP_MRW) ? 2'h3 : 2'h1;
    wire       tmr_done = (tmr_sys_q == 16'h0000) &&
                          (tmr_ck_q == 16'h0000) && armed_q;

    // which orders the device state permits
    always @* begin
        req_ok = 1'b0;
        if (in_pd_q) begin
            req_ok = (req_op == `SRH_OP_PDX);
        end else if (in_sr_q) begin
            // only the restricted set, and no mask changes; see R4
            case (req_op)
            `SRH_OP_SRX: req_ok = 1'b1;
            `SRH_OP_PDE: req_ok = 1'b1;
            `SRH_OP_MRR: req_ok = 1'b1;
            `SRH_OP_MRW: req_ok = !mask_ma;
            default:     req_ok = 1'b0;
            endcase
        end else begin
            case (req_op)
            `SRH_OP_SRE:   req_ok = !owed_q; // see R12, R22
            `SRH_OP_MRR:   req_ok = 1'b1;
            `SRH_OP_MRW:   req_ok = 1'b1;
            `SRH_OP_REFAB: req_ok = 1'b1;
            `SRH_OP_REFPB: req_ok = 1'b1;
            default:       req_ok = 1'b0;
            endcase
        end
    end

    // wait lengths: time and clock count must both run out; see R9
    always @* begin
        ld_sys = 16'h0000;
        ld_ck  = 16'h0000;
        case (op_q)
        `SRH_OP_SRE: begin
            // residency covers the cke-high delay too; see R6, R7
            ld_sys = max16(cyc(`SRH_ESCKE_PS), cyc(`SRH_SR_PS));
            ld_ck  = max16(`SRH_ESCKE_NCK, `SRH_SR_NCK);
        end
        `SRH_OP_SRX: begin
            // shorter wait when abort is enabled; see R8, R11
            ld_sys = abort_en_q ?
                     cyc(`SRH_RFCPB_PS + `SRH_ABORT_ADD_PS) :
                     cyc(`SRH_RFCAB_PS + `SRH_XSR_ADD_PS);
            ld_ck  = `SRH_XSR_NCK;
        end
        `SRH_OP_PDE: ld_ck = CKELCK_NCK; // see R5
        `SRH_OP_PDX: ld_ck = CKCKEH_NCK; // see R5
        `SRH_OP_MRR: ld_ck = `SRH_MRR_NCK; // see R19
        `SRH_OP_MRW: begin
            ld_sys = cyc(`SRH_MRW_PS);
            ld_ck  = `SRH_MRW_NCK;
        end
        `SRH_OP_REFAB: ld_sys = cyc(`SRH_RFCAB_PS);
        `SRH_OP_REFPB: ld_sys = cyc(`SRH_RFCPB_PS);
        default: begin
            ld_sys = 16'h0000;
            ld_ck  = 16'h0000;
        end
        endcase
    end

    // link clock divider; a stopped clock parks low
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            div_cnt_q <= 8'h00;
            ck_q      <= 1'b0;
        end else if (edge_now) begin
            div_cnt_q <= 8'h00;
            ck_q      <= ck_run_q ? ~ck_q : 1'b0;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    // data lanes come from the far clock domain
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
        end
    end

    // software register file
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            arg_q   <= 16'h0000;
            err_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            if (wr_en && (addr == `SRH_REG_ARG))
                arg_q <= wdata[15:0];
            // a refusal in the clearing cycle still sticks
            if (go && !accept)
                err_q <= 1'b1;
            else if (ctrl_wr && wdata[`SRH_CTRL_CLR])
                err_q <= 1'b0;
            rdata_q <= 32'h00000000;
            if (rd_en) begin
                case (addr)
                `SRH_REG_ARG:    rdata_q <= {16'h0000, arg_q};
                `SRH_REG_STATUS: rdata_q <= {16'h0000, mr_data_q, 2'h0,
                                             err_q, abort_en_q, owed_q,
                                             in_pd_q, in_sr_q, !idle};
                default:         rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // command sequencer and device state tracking
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q    <= S_IDLE;
            op_q       <= `SRH_OP_SRE;
            phase_q    <= 2'h0;
            tmr_sys_q  <= 16'h0000;
            tmr_ck_q   <= 16'h0000;
            armed_q    <= 1'b0;
            cap_pend_q <= 1'b0;
            cap_ck_q   <= 16'h0000;
            cap_sys_q  <= 16'h0000;
            mr_data_q  <= 8'h00;
            ck_run_q   <= 1'b1;
            cke_q      <= 1'b1;
            cs_q       <= 1'b0;
            ca_q       <= `SRH_CA_DES;
            in_sr_q    <= 1'b0;
            in_pd_q    <= 1'b0;
            owed_q     <= 1'b0;
            pb_cnt_q   <= 3'h0;
            abort_en_q <= 1'b0;
        end else begin
            // deselect on every falling edge outside a command
            if (fall && state_q != S_CMD) begin
                cs_q <= 1'b0;
                ca_q <= `SRH_CA_DES;
            end
            case (state_q)
            S_IDLE: begin
                if (accept) begin
                    op_q    <= req_op;
                    phase_q <= 2'h0;
                    armed_q <= 1'b0;
                    if (req_op == `SRH_OP_PDE) begin
                        cke_q   <= 1'b0;
                        in_pd_q <= 1'b1;
                        state_q <= S_WAIT;
                    end else if (req_op == `SRH_OP_PDX) begin
                        ck_run_q <= 1'b1; // restart clock first; see R5
                        state_q  <= S_WAIT;
                    end else begin
                        state_q <= S_CMD;
                    end
                end
            end
            S_CMD: begin
                // lanes change on the fall, device samples on the rise
                if (fall) begin
                    cs_q    <= !phase_q[0];
                    ca_q    <= ca_word(op_q, phase_q, arg_q[5:0],
                                       arg_q[15:8]);
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == last_ph) begin
                        state_q <= S_WAIT;
                        if (op_q == `SRH_OP_SRE)
                            in_sr_q <= 1'b1;
                        if (op_q == `SRH_OP_SRX) begin
                            in_sr_q  <= 1'b0;
                            owed_q   <= 1'b1; // see R12
                            pb_cnt_q <= 3'h0;
                        end
                        if (op_q == `SRH_OP_REFAB)
                            owed_q <= 1'b0;
                        if (op_q == `SRH_OP_REFPB) begin
                            pb_cnt_q <= pb_cnt_q + 3'h1;
                            if (pb_cnt_q == `SRH_PB_LAST)
                                owed_q <= 1'b0;
                        end
                        if (op_q == `SRH_OP_MRW &&
                            arg_q[5:0] == `SRH_MA_ABORT)
                            abort_en_q <= arg_q[8 + `SRH_ABORT_BIT];
                        if (op_q == `SRH_OP_MRR) begin
                            cap_pend_q <= 1'b1;
                            cap_ck_q   <= RL_NCK;
                            cap_sys_q  <= SAMPLE_DLY;
                        end
                    end
                end
            end
            S_WAIT: begin
                // arm on the command edge so both counts start there
                if (!armed_q) begin
                    if (rise) begin
                        armed_q   <= 1'b1;
                        tmr_sys_q <= ld_sys;
                        tmr_ck_q  <= ld_ck;
                    end
                end else begin
                    if (tmr_sys_q != 16'h0000)
                        tmr_sys_q <= tmr_sys_q - 16'h0001;
                    if (rise && tmr_ck_q != 16'h0000)
                        tmr_ck_q <= tmr_ck_q - 16'h0001;
                end
                // mode read capture; the burst is never cut short
                if (armed_q && cap_pend_q) begin // see R18
                    if (cap_ck_q != 16'h0000) begin
                        if (rise)
                            cap_ck_q <= cap_ck_q - 16'h0001;
                    end else if (cap_sys_q != 16'h0000) begin
                        cap_sys_q <= cap_sys_q - 16'h0001;
                    end else begin
                        // only lanes 0-7 carry the register; see R16, R17
                        mr_data_q  <= dq_s2_q;
                        cap_pend_q <= 1'b0;
                    end
                end
                if (tmr_done && !cap_pend_q) begin
                    state_q <= S_IDLE;
                    if (op_q == `SRH_OP_PDE)
                        ck_run_q <= 1'b0; // stop after lock delay
                    if (op_q == `SRH_OP_PDX) begin
                        cke_q   <= 1'b1;
                        in_pd_q <= 1'b0;
                    end
                end
            end
            default: state_q <= S_IDLE;
            endcase
        end
    end

    assign rdata  = rdata_q;
    assign ck_out = ck_q;
    assign cke    = cke_q;
    assign cs     = cs_q;
    assign ca     = ca_q;

endmodule

//--- inc/srh_defines.vh
// constants for the self refresh / mode read host controller
// Functional notes
// R1 - device splits each bank into eight segments
// R2 - refresh only where bank and segment unmasked
// R3 - reserved mask register writes change nothing
// R4 - in self refresh: restricted commands, no masks
// R5 - clock may stop after lock, stable before exit
// R6 - cke stays high after entry for entry delay
// R7 - stay in self refresh for minimum residency
// R8 - wait exit delay before unrestricted commands
// R9 - delays need both time and clock count
// R10 - abort enable drops refresh in progress
// R11 - abort enabled: shorter abort exit delay
// R12 - one extra refresh before next entry
// R13 - device takes mode commands during exit delay
// R14 - device takes mode commands during refresh
// R15 - mode read carries six bit register address
// R16 - register bits on lanes 0-7, four beats
// R17 - mode read is sixteen beats, strobe toggling
// R18 - never interrupt a mode read
// R19 - only deselect during mode read period
// R20 - inversion lane low if not applied
// R21 - mode read strobe framing like normal read
// R22 - entry only after reads done, device idle
// R23 - masked bank gets no self refresh
// R24 - segment bit i masks segment i, one=masked
`ifndef SRH_DEFINES_VH
`define SRH_DEFINES_VH

// software register offsets
`define SRH_REG_CTRL   4'h0
`define SRH_REG_ARG    4'h1
`define SRH_REG_STATUS 4'h2

// control word fields
`define SRH_CTRL_GO    0
`define SRH_CTRL_OP_LO 1
`define SRH_CTRL_OP_HI 3
`define SRH_CTRL_CLR   7

// operations
`define SRH_OP_SRE   3'h0
`define SRH_OP_SRX   3'h1
`define SRH_OP_PDE   3'h2
`define SRH_OP_PDX   3'h3
`define SRH_OP_MRR   3'h4
`define SRH_OP_MRW   3'h5
`define SRH_OP_REFAB 3'h6
`define SRH_OP_REFPB 3'h7

// first-edge command codes on the command/address lanes
`define SRH_CA_SRE   6'h18
`define SRH_CA_SRX   6'h14
`define SRH_CA_MRR   6'h0e
`define SRH_CA_MRW1  6'h06
`define SRH_CA_MRW2  6'h16
`define SRH_CA_REFAB 6'h08
`define SRH_CA_REFPB 6'h28
`define SRH_CA_DES   6'h00

// mode register addresses the host guards
`define SRH_MA_BANK_MASK 6'h10
`define SRH_MA_SEG_MASK  6'h11
`define SRH_MA_ABORT     6'h04
`define SRH_ABORT_BIT    3

// timing, picoseconds and clock counts
`define SRH_SYS_PS       32'h000186a0
`define SRH_ESCKE_PS     32'h000006d6
`define SRH_ESCKE_NCK    16'h0003
`define SRH_SR_PS        32'h00003a98
`define SRH_SR_NCK       16'h0003
`define SRH_XSR_ADD_PS   32'h00001d4c
`define SRH_XSR_NCK      16'h0002
`define SRH_ABORT_ADD_PS 32'h0000445c
`define SRH_RFCAB_PS     32'h000445c0
`define SRH_RFCPB_PS     32'h000222e0
`define SRH_MRR_NCK      16'h0008
`define SRH_MRW_PS       32'h00002710
`define SRH_MRW_NCK      16'h000a
`define SRH_PB_LAST      3'h7

`endif

//--- verification/srh_host_assertions.sv
// checker for link command spacing and clock enable timing
`include "srh_defines.vh"
module srh_host_assertions #(
    parameter [7:0] DIV = 8'h04
) (
    input wire       clk_sys,
    input wire       rst_n,
    input wire       ck_out,
    input wire       cke,
    input wire       cs,
    input wire [5:0] ca
);
    timeunit 1ns;
    timeprecision 1ps;
    reg       ck_q;
    reg       in_sr_q;
    reg       mrw_q;
    reg [7:0] gap_q;
    reg [7:0] idle_q;
    reg [5:0] last_q;
    wire      rise = ck_out & ~ck_q;
    wire      cmd  = rise & cs;

    // link rises seen since the last command, self refresh as device sees it
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ck_q <= 1'b0;
            in_sr_q <= 1'b0;
            mrw_q <= 1'b0;
            gap_q <= 8'hff;
            idle_q <= 8'h00;
            last_q <= 6'h00;
        end else begin
            ck_q <= ck_out;
            if (cmd) begin
                gap_q <= 8'h00;
                last_q <= ca;
            end else if (rise && gap_q != 8'hff) begin
                gap_q <= gap_q + 8'h01;
            end
            if (cmd && ca == `SRH_CA_SRE)
                in_sr_q <= 1'b1;
            if (cmd && ca == `SRH_CA_SRX)
                in_sr_q <= 1'b0;
            if (rise)
                mrw_q <= cs && ca[4:0] == 5'h06;
            // saturates so a long stop cannot wrap back to zero
            if (ck_out != ck_q)
                idle_q <= 8'h00;
            else if (idle_q != 8'hff)
                idle_q <= idle_q + 8'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_cs_width;
        $rose(cs) |-> cs [*8] ##1 !cs;
    endproperty
    a_cs_width: assert property (p_cs_width)
        else $error("chip select not one link period");
    property p_sr_stay;
        cmd && last_q == `SRH_CA_SRE |-> gap_q >= 8'h03;
    endproperty
    a_sr_stay: assert property (p_sr_stay)
        else $error("self refresh left too early");
    property p_exit_wait;
        cmd && last_q == `SRH_CA_SRX |-> gap_q >= 8'h02;
    endproperty
    a_exit_wait: assert property (p_exit_wait)
        else $error("command too soon after exit");
    property p_mrr_quiet;
        cmd && last_q == `SRH_CA_MRR |-> gap_q >= 8'h08;
    endproperty
    a_mrr_quiet: assert property (p_mrr_quiet)
        else $error("command inside mode read period");
    property p_cke_entry;
        $fell(cke) |-> in_sr_q && (last_q != `SRH_CA_SRE || gap_q >= 8'h03);
    endproperty
    a_cke_entry: assert property (p_cke_entry)
        else $error("clock enable dropped too early");
    property p_mask_lock;
        rise && mrw_q && in_sr_q |-> ca != 6'h10 && ca != 6'h11;
    endproperty
    a_mask_lock: assert property (p_mask_lock)
        else $error("mask register written in self refresh");
    property p_clk_stop;
        idle_q >= {DIV, 1'b0} |-> !cke;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("link clock stopped outside power-down");
    property p_srx_in_sr;
        cmd && ca == `SRH_CA_SRX |-> in_sr_q && cke;
    endproperty
    a_srx_in_sr: assert property (p_srx_in_sr)
        else $error("exit issued outside self refresh");
endmodule

bind srh_host srh_host_assertions #(.DIV(DIV)) u_chk (
    .clk_sys(clk_sys),
    .rst_n  (rst_n),
    .ck_out (ck_out),
    .cke    (cke),
    .cs     (cs),
    .ca     (ca)
);

//--- verification/srh_dev_model.sv
// behavioural memory device: mode registers, refresh state, mode read data
`include "srh_defines.vh"
module srh_dev_model #(
    parameter [15:0] RL_NCK = 16'h000e,
    parameter [5:0]  RSV_MA = 6'h12
) (
    input  wire       ck,
    input  wire       cke,
    input  wire       cs,
    input  wire [5:0] ca,
    output reg  [7:0] dq
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [7:0]  mr [0:63];
    reg  [2:0]  st;
    reg  [5:0]  ma;
    reg  [7:0]  wd;
    reg  [15:0] lat;
    reg  [3:0]  beat;
    reg  [15:0] row;
    wire [63:0] kept;
    integer     i;
    genvar      g;

    // region bank*8+seg kept alive: a one in either mask drops it
    for (g = 0; g < 64; g = g + 1) begin : kp
        assign kept[g] = ~mr[`SRH_MA_BANK_MASK][g/8]
                       & ~mr[`SRH_MA_SEG_MASK][g%8];
    end

    initial begin
        for (i = 0; i < 64; i = i + 1)
            mr[i] = 8'h00;
        st = 3'h0;
        lat = 16'h0000;
        beat = 4'h0;
        row = 16'h0000;
        dq = 8'ha5;
    end

    // decode at every link rise while cke is high; timing is never policed here
    always @(posedge ck) begin
        if (lat != 16'h0000)
            lat <= lat - 16'h0001;
        if (beat != 4'h0)
            beat <= beat - 4'h1; // 8 clocks = 16 beats
        if (lat == 16'h0001) begin
            dq <= mr[ma]; // never inverted
            beat <= 4'h8;
        end else if (beat != 4'h8) begin
            dq <= ~dq; // undefined after the held beats
        end
        if (cke) begin
            case (st)
                3'h0: if (cs && ca == `SRH_CA_MRR) begin
                    st <= 3'h1;
                end else if (cs && ca[4:0] == 5'h06) begin
                    wd[7] <= ca[5];
                    st <= 3'h2;
                end else if (cs && ca == `SRH_CA_SRX) begin
                    if (!mr[`SRH_MA_ABORT][`SRH_ABORT_BIT])
                        row <= row + 16'h0001;
                end
                3'h1: begin
                    ma <= ca; // accepted in any state
                    lat <= RL_NCK; // same latency as a plain read
                    st <= 3'h0;
                end
                3'h2: begin
                    ma <= ca;
                    st <= 3'h3;
                end
                3'h3: begin
                    wd[6] <= ca[5];
                    st <= (cs && ca[4:0] == 5'h16) ? 3'h4 : 3'h0;
                end
                default: begin
                    if (ma != RSV_MA)
                        mr[ma] <= {wd[7:6], ca};
                    st <= 3'h0;
                end
            endcase
        end
    end
endmodule

//--- verification/tb_srh_host.sv
// self-checking bench for the self refresh host controller
`include "srh_defines.vh"
module tb_srh_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_n, wr_en, rd_en, ck_out, cke, cs;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, s;
    logic [5:0]  ca, a;
    logic [7:0]  dq, d, last;
    logic [7:0]  mr [64];
    logic [63:0] kp;
    bit          sr, pd, owed, abrt, err;
    int          err_total, n_compared, cyc, pb, i, rows;

    srh_host dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ck_out(ck_out), .cke(cke), .cs(cs), .ca(ca), .dq_in(dq));
    srh_dev_model dev_u (.ck(ck_out), .cke(cke), .cs(cs), .ca(ca), .dq(dq));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            give_verdict();
        end
    end

    task give_verdict();
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task wr(input [3:0] ad, input [31:0] v);
        @(posedge clk_sys);
        addr <= ad;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task rd(input [3:0] ad, output [31:0] v);
        @(posedge clk_sys);
        addr <= ad;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        @(negedge clk_sys);
        v = rdata;
    endtask
    function logic [31:0] stat();
        return {16'h0, last, 2'b0, err, abrt, owed, pd, sr, 1'b0};
    endfunction
    // one operation, reference model updated only when it is legal
    task op(input [2:0] o, input [5:0] ma, input [7:0] v);
        bit ok;
        int n;
        ok = pd ? o == `SRH_OP_PDX : sr ? (o == `SRH_OP_SRX
            || o == `SRH_OP_PDE || o == `SRH_OP_MRR || (o == `SRH_OP_MRW
            && ma != 6'h10 && ma != 6'h11 && ma != 6'h04))
            : (o != `SRH_OP_SRX && o[2:1] != 2'b01 && !(o == 0 && owed));
        wr(`SRH_REG_ARG, {16'h0, v, 2'b00, ma});
        wr(`SRH_REG_CTRL, {28'h0, o, 1'b1});
        n = 0;
        do begin
            rd(`SRH_REG_STATUS, s);
            n++;
        end while (s[0] !== 1'b0 && n < 3000);
        if (!ok)
            err = 1;
        else case (o)
            `SRH_OP_SRE: sr = 1;
            `SRH_OP_SRX: begin
                {sr, owed, pb} = {1'b0, 1'b1, 32'd0};
                if (!abrt)
                    rows++; // row counter moves on only without abort
            end
            `SRH_OP_PDE: pd = 1;
            `SRH_OP_PDX: pd = 0;
            `SRH_OP_MRR: last = mr[ma];
            `SRH_OP_MRW: begin
                if (ma != 6'h12)
                    mr[ma] = v; // reserved place stays zero
                if (ma == 6'h04)
                    abrt = v[3];
            end
            `SRH_OP_REFAB: owed = 0;
            default: begin
                pb++;
                if (pb == 8)
                    owed = 0;
            end
        endcase
        chk("status", stat(), s);
        chk("row", rows, dev_u.row);
    endtask
    task clr();
        wr(`SRH_REG_CTRL, 32'h80);
        err = 0;
    endtask

    initial begin
        {rst_n, wr_en, rd_en, addr, wdata, last} = '0;
        foreach (mr[k])
            mr[k] = 8'h00;
        void'($urandom(31971));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        // plain register access, an unmapped place, reset state
        wr(4'hf, $urandom);
        rd(4'hf, s);
        chk("unmapped", 32'h0, s);
        wr(`SRH_REG_ARG, 32'ha51c);
        rd(`SRH_REG_ARG, s);
        chk("arg", 32'ha51c, s);
        rd(`SRH_REG_STATUS, s);
        chk("status", stat(), s);
        // random mode writes read back, masks among them
        for (i = 0; i < 8; i++) begin
            a = (i < 2) ? 6'h10 + i : $urandom % 64;
            d = $urandom;
            op(`SRH_OP_MRW, a, d);
            op(`SRH_OP_MRR, a, 8'h0);
        end
        // self refresh: guarded writes, reads, power-down
        op(`SRH_OP_SRE, 0, 0);
        op(`SRH_OP_MRW, 6'h11, 8'h84);
        clr();
        op(`SRH_OP_MRR, 6'h11, 8'h0);
        // a legal write inside self refresh, to the reserved place
        op(`SRH_OP_MRW, 6'h12, $urandom);
        op(`SRH_OP_MRR, 6'h12, 8'h0);
        // refreshed regions follow both masks, refused write left them
        for (i = 0; i < 64; i++)
            kp[i] = !mr[6'h10][i / 8] && !mr[6'h11][i % 8];
        chk("kept_lo", kp[31:0], dev_u.kept[31:0]);
        chk("kept_hi", kp[63:32], dev_u.kept[63:32]);
        op(`SRH_OP_PDE, 0, 0);
        op(`SRH_OP_MRR, 6'h11, 8'h0);
        clr();
        op(`SRH_OP_PDX, 0, 0);
        op(`SRH_OP_SRX, 0, 0);
        op(`SRH_OP_SRE, 0, 0);
        clr();
        op(`SRH_OP_REFAB, 0, 0);
        // abort enabled, debt repaid by per-bank refreshes
        op(`SRH_OP_MRW, 6'h04, 8'h08);
        op(`SRH_OP_SRE, 0, 0);
        op(`SRH_OP_SRX, 0, 0);
        for (i = 0; i < 8; i++)
            op(`SRH_OP_REFPB, 0, 0);
        op(`SRH_OP_SRE, 0, 0);
        op(`SRH_OP_SRX, 0, 0);
        give_verdict();
    end
endmodule
